// ===== rtl/ummd_decoder.sv
`timescale 1ns/1ps
module ummd_decoder #(
	parameter ummd_pkg::ummd_variant_t VARIANT = ummd_pkg::UMMD_F32,
	parameter logic [127:0] CORE_SFR_MASK = 128'h0
)(
	input wire logic CLK,
	input wire logic RESET_N,
	input wire logic CE,
	input wire logic [15:0] U_ADDR,
	input wire logic U_RD,
	input wire logic U_WR,
	input wire logic U_FETCH,
	input wire logic U_DMA,
	input wire logic [7:0] U_WDATA,
	output logic [7:0] U_RDATA,
	output logic U_VALID,
	output logic [2:0] U_REGION,
	input wire logic [7:0] D_ADDR,
	input wire logic D_INDIRECT,
	input wire logic D_RD,
	input wire logic D_WR,
	input wire logic [7:0] D_WDATA,
	input wire logic D_BIT,
	input wire logic [2:0] D_BITSEL,
	output logic [7:0] D_RDATA,
	output logic D_SFR_SEL,
	output logic [6:0] D_SFR_IDX,
	output logic D_SFR_CORE,
	output logic D_IN_BANK,
	output logic D_BITOK,
	input wire logic [1:0] POWER_MODE,
	input wire logic PM_EXIT,
	input wire logic DBG_INFO_PAGE,
	output logic INFO_PAGE_SEL,
	output logic [5:0] FLASH_PAGE,
	output logic CACHE_BYPASS,
	output logic [31:0] FLASH_READS
);
	logic [7:0] idata_q [256];
	logic [7:0] sram_q [ummd_pkg::SRAM_BYTES];
	logic [7:0] flash_q [ummd_pkg::FLASH_BYTES];
	logic [7:0] memctl_q;
	logic [1:0] pm_sync1_q, pm_sync2_q;
	logic exit_s1_q, exit_s2_q, dbg_s1_q, dbg_s2_q;
	logic [15:0] flash_end;
	logic [15:0] hole_lo;
	logic has_hole;
	ummd_pkg::ummd_region_t region;
	logic sfr_core_mirror;
	logic [13:0] tag_q;
	logic tag_v_q;
	logic [7:0] line_q [ummd_pkg::LINE_WORDS];
	logic hit;
	logic [31:0] freads_q;
	logic [7:0] dsel;
	logic d_is_sfr;
	logic [7:0] sfr_q [128];
	// variant-dependent limits
	always_comb
	begin
		unique case (VARIANT)
			ummd_pkg::UMMD_F8:
			begin
				flash_end = ummd_pkg::FLASH_END_8K;
				hole_lo = ummd_pkg::HOLE_8K_LO;
				has_hole = 1'b1;
			end
			ummd_pkg::UMMD_F16:
			begin
				flash_end = ummd_pkg::FLASH_END_16K;
				hole_lo = ummd_pkg::HOLE_16K_LO;
				has_hole = 1'b1;
			end
			default:
			begin
				flash_end = ummd_pkg::FLASH_END_32K;
				hole_lo = ummd_pkg::HOLE_HI;
				has_hole = 1'b0;
			end
		endcase
	end
	// one region per address, fetch and data alike
	always_comb
	begin
		if (U_ADDR <= flash_end)
			region = ummd_pkg::RG_FLASH;
		else if (U_ADDR >= ummd_pkg::SFR_MIRROR_LO && U_ADDR <= ummd_pkg::SFR_MIRROR_HI)
			region = ummd_pkg::RG_SFR;
		else if (has_hole && U_ADDR >= hole_lo && U_ADDR <= ummd_pkg::HOLE_HI)
			region = ummd_pkg::RG_HOLE;
		else if (U_ADDR >= ummd_pkg::SRAM_LO)
			region = ummd_pkg::RG_SRAM;
		else
			region = ummd_pkg::RG_NONE;
	end
	assign U_REGION = region;
	assign sfr_core_mirror = (region == ummd_pkg::RG_SFR) && CORE_SFR_MASK[U_ADDR[6:0]];
	assign U_VALID = (U_RD | U_WR | U_FETCH | U_DMA) && region != ummd_pkg::RG_NONE
		&& region != ummd_pkg::RG_HOLE && !sfr_core_mirror;
	// native data/sfr side
	assign d_is_sfr = D_ADDR >= ummd_pkg::UPPER_HALF && !D_INDIRECT;
	assign D_SFR_SEL = d_is_sfr;
	assign D_SFR_IDX = D_ADDR[6:0];
	assign D_SFR_CORE = d_is_sfr && CORE_SFR_MASK[D_ADDR[6:0]];
	assign D_IN_BANK = D_ADDR <= ummd_pkg::BANK_TOP;
	assign D_BITOK = d_is_sfr ? (D_ADDR[2:0] == 3'h0)
		: (D_ADDR >= ummd_pkg::BITBYTE_LO && D_ADDR <= ummd_pkg::BITBYTE_HI);
	assign dsel = D_ADDR;
	// two-flop sync of power controller and debug inputs
	always_ff @(posedge CLK or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			pm_sync1_q <= 2'h0;
			pm_sync2_q <= 2'h0;
			exit_s1_q <= 1'b0;
			exit_s2_q <= 1'b0;
			dbg_s1_q <= 1'b0;
			dbg_s2_q <= 1'b0;
		end
		else if (CE)
		begin
			pm_sync1_q <= POWER_MODE;
			pm_sync2_q <= pm_sync1_q;
			exit_s1_q <= PM_EXIT;
			exit_s2_q <= exit_s1_q;
			dbg_s1_q <= DBG_INFO_PAGE;
			dbg_s2_q <= dbg_s1_q;
		end
	end
	assign INFO_PAGE_SEL = dbg_s2_q;
	assign FLASH_PAGE = {1'b0, U_ADDR[14:10]};
	// control register, retained through every power mode
	always_ff @(posedge CLK or negedge RESET_N)
	begin
		if (!RESET_N)
			memctl_q <= ummd_pkg::MEMCTL_RESET;
		else if (CE)
		begin
			if (D_WR && d_is_sfr && D_ADDR == ummd_pkg::MEMCTL_ADDR)
				memctl_q <= D_WDATA;
			else if (U_WR && region == ummd_pkg::RG_SFR && !sfr_core_mirror
				&& U_ADDR[7:0] == ummd_pkg::MEMCTL_ADDR)
				memctl_q <= U_WDATA;
		end
	end
	assign CACHE_BYPASS = memctl_q[ummd_pkg::MEMCTL_CACHE_BIT];
	// storage standing in for the other sfr owners, native or mirrored
	always_ff @(posedge CLK)
	begin
		if (CE)
		begin
			if (D_WR && d_is_sfr && D_ADDR != ummd_pkg::MEMCTL_ADDR)
				sfr_q[D_ADDR[6:0]] <= D_WDATA;
			else if (U_WR && region == ummd_pkg::RG_SFR && !sfr_core_mirror
				&& U_ADDR[7:0] != ummd_pkg::MEMCTL_ADDR)
				sfr_q[U_ADDR[6:0]] <= U_WDATA;
		end
	end
	// internal data memory: no reset, kept in all modes
	always_ff @(posedge CLK)
	begin
		if (CE)
		begin
			if (D_WR && !d_is_sfr)
			begin
				if (D_BIT)
					idata_q[dsel][D_BITSEL] <= D_WDATA[0];
				else
					idata_q[dsel] <= D_WDATA;
			end
			else if (U_WR && region == ummd_pkg::RG_SRAM && U_ADDR >= ummd_pkg::DATA_ALIAS_LO)
				idata_q[U_ADDR[7:0]] <= U_WDATA;
		end
	end
	// sram, contents undefined at power-on volatile bytes scrambled
	always_ff @(posedge CLK)
	begin
		if (CE)
		begin
			if (U_WR && region == ummd_pkg::RG_SRAM && U_ADDR < ummd_pkg::DATA_ALIAS_LO)
				sram_q[U_ADDR[11:0]] <= U_WDATA;
			else if (VARIANT == ummd_pkg::UMMD_F32 && exit_s2_q
				&& (pm_sync2_q == ummd_pkg::PM_TWO || pm_sync2_q == ummd_pkg::PM_THREE)
				&& U_ADDR >= ummd_pkg::VOLATILE_LO && U_ADDR <= ummd_pkg::HOLE_HI)
				sram_q[U_ADDR[11:0]] <= 8'hFF;
		end
	end
	// instruction cache: one line of four bytes
	assign hit = tag_v_q && tag_q == U_ADDR[15:2] && !CACHE_BYPASS;
	always_ff @(posedge CLK or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			tag_v_q <= 1'b0;
			tag_q <= 14'h0;
			freads_q <= 32'h0;
		end
		else if (CE)
		begin
			if (U_FETCH && region == ummd_pkg::RG_FLASH && !hit)
			begin
				freads_q <= freads_q + 32'h1;
				tag_q <= U_ADDR[15:2];
				tag_v_q <= !CACHE_BYPASS;
			end
		end
	end
	always_ff @(posedge CLK)
	begin
		if (CE && U_FETCH && region == ummd_pkg::RG_FLASH && !hit)
			for (int i = 0; i < ummd_pkg::LINE_WORDS; i++)
				line_q[i] <= flash_q[{U_ADDR[14:2], i[1:0]}];
	end
	assign FLASH_READS = freads_q;
	// read data registers
	always_ff @(posedge CLK or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			U_RDATA <= 8'h00;
			D_RDATA <= 8'h00;
		end
		else if (CE)
		begin
			if (region == ummd_pkg::RG_FLASH)
				U_RDATA <= (U_FETCH && hit) ? line_q[U_ADDR[1:0]] : flash_q[U_ADDR[14:0]];
			else if (region == ummd_pkg::RG_SRAM)
				U_RDATA <= (U_ADDR >= ummd_pkg::DATA_ALIAS_LO) ? idata_q[U_ADDR[7:0]]
					: sram_q[U_ADDR[11:0]];
			else if (region == ummd_pkg::RG_SFR && !sfr_core_mirror)
				U_RDATA <= (U_ADDR[7:0] == ummd_pkg::MEMCTL_ADDR) ? memctl_q
					: sfr_q[U_ADDR[6:0]];
			else
				U_RDATA <= 8'h00;
			if (d_is_sfr)
				D_RDATA <= (D_ADDR == ummd_pkg::MEMCTL_ADDR) ? memctl_q : sfr_q[D_ADDR[6:0]];
			else
				D_RDATA <= idata_q[dsel];
		end
	end
	// flash storage written through the write data port sfr, except while the information page is selected
	always_ff @(posedge CLK)
	begin
		if (CE && D_WR && d_is_sfr && D_ADDR == ummd_pkg::FLASH_WRITE_DATA_PORT_PORT_ADDR && !dbg_s2_q)
			flash_q[U_ADDR[14:0]] <= D_WDATA;
	end
	one_region_a: assert property (@(posedge CLK) disable iff (!RESET_N)
		U_ADDR <= flash_end |-> region == ummd_pkg::RG_FLASH) else $error("flash decode");
	mirror_a: assert property (@(posedge CLK) disable iff (!RESET_N)
		(U_ADDR >= ummd_pkg::SFR_MIRROR_LO && U_ADDR <= ummd_pkg::SFR_MIRROR_HI)
		|-> region == ummd_pkg::RG_SFR) else $error("mirror decode");
	core_block_a: assert property (@(posedge CLK) disable iff (!RESET_N)
		sfr_core_mirror |-> !U_VALID) else $error("core sfr via mirror");
	direct_sfr_a: assert property (@(posedge CLK) disable iff (!RESET_N)
		(D_ADDR >= ummd_pkg::UPPER_HALF && !D_INDIRECT) |-> D_SFR_SEL) else $error("direct sfr");
	bypass_count_a: assert property (@(posedge CLK) disable iff (!RESET_N)
		(CE && CACHE_BYPASS && U_FETCH && region == ummd_pkg::RG_FLASH)
		|=> FLASH_READS == $past(FLASH_READS) + 32'h1) else $error("bypass fetch");
	memctl_keep_a: assert property (@(posedge CLK) disable iff (!RESET_N)
		(CE && exit_s2_q && pm_sync2_q == ummd_pkg::PM_THREE && !D_WR && !U_WR)
		|=> memctl_q == $past(memctl_q)) else $error("memctl lost");
	bitok_a: assert property (@(posedge CLK) disable iff (!RESET_N)
		(!D_SFR_SEL && D_ADDR == ummd_pkg::BITBYTE_LO) |-> D_BITOK) else $error("bit byte");
	hole_a: assert property (@(posedge CLK) disable iff (!RESET_N)
		(has_hole && U_ADDR >= hole_lo && U_ADDR <= ummd_pkg::HOLE_HI) |-> !U_VALID)
		else $error("hole valid");
	cov_fetch_c: cover property (@(posedge CLK) U_FETCH && hit);
	cov_mirror_c: cover property (@(posedge CLK) U_WR && region == ummd_pkg::RG_SFR);
	alias_rd_a: assert property (@(posedge CLK) disable iff (!RESET_N)
		(CE && U_RD && U_ADDR >= ummd_pkg::DATA_ALIAS_LO && !D_WR && !U_WR)
		|=> U_RDATA == $past(idata_q[U_ADDR[7:0]])) else $error("alias read");
	bank_a: assert property (@(posedge CLK) disable iff (!RESET_N)
		D_IN_BANK == (D_ADDR <= ummd_pkg::BANK_TOP)) else $error("bank range");
	sram_region_a: assert property (@(posedge CLK) disable iff (!RESET_N)
		(U_ADDR >= ummd_pkg::SRAM_LO && !(has_hole && U_ADDR >= hole_lo && U_ADDR <= ummd_pkg::HOLE_HI))
		|-> region == ummd_pkg::RG_SRAM) else $error("sram decode");
	gap_a: assert property (@(posedge CLK) disable iff (!RESET_N)
		region == ummd_pkg::RG_NONE |-> (U_ADDR > flash_end && U_ADDR < ummd_pkg::SFR_MIRROR_LO)
		|| (U_ADDR > ummd_pkg::SFR_MIRROR_HI && U_ADDR < ummd_pkg::SRAM_LO)) else $error("gap");
	hit_quiet_a: assert property (@(posedge CLK) disable iff (!RESET_N)
		(CE && U_FETCH && hit)
		|=> FLASH_READS == $past(FLASH_READS)) else $error("hit counted");
	page_a: assert property (@(posedge CLK) disable iff (!RESET_N)
		region == ummd_pkg::RG_FLASH |-> FLASH_PAGE[4:0] == U_ADDR[14:10]) else $error("page");
	info_block_a: assert property (@(posedge CLK) disable iff (!RESET_N)
		(CE && INFO_PAGE_SEL && D_WR && D_SFR_SEL && D_ADDR == ummd_pkg::FLASH_WRITE_DATA_PORT_PORT_ADDR)
		|=> flash_q[$past(U_ADDR[14:0])] == $past(flash_q[U_ADDR[14:0]])) else $error("info");
	sfr_bit_a: assert property (@(posedge CLK) disable iff (!RESET_N)
		(D_SFR_SEL && D_ADDR[2:0] == 3'h0) |-> D_BITOK) else $error("sfr bit");
	idx_a: assert property (@(posedge CLK) disable iff (!RESET_N)
		D_SFR_SEL |-> D_SFR_IDX == D_ADDR[6:0]) else $error("sfr index");
	dma_core_a: assert property (@(posedge CLK) disable iff (!RESET_N)
		(U_DMA && sfr_core_mirror) |-> !U_VALID) else $error("dma core sfr");
	core_rd_a: assert property (@(posedge CLK) disable iff (!RESET_N)
		(CE && sfr_core_mirror) |=> U_RDATA == 8'h00) else $error("core sfr data");
	retain_a: assert property (@(posedge CLK) disable iff (!RESET_N)
		(CE && !D_WR && !U_WR)
		|=> idata_q[$past(D_ADDR)] == $past(idata_q[D_ADDR])) else $error("data lost");
	mirror_wr_a: assert property (@(posedge CLK) disable iff (!RESET_N)
		(CE && U_WR && !D_WR && region == ummd_pkg::RG_SFR && !sfr_core_mirror
		&& U_ADDR[7:0] == ummd_pkg::MEMCTL_ADDR) |=> memctl_q == $past(U_WDATA))
		else $error("mirror write");
	freeze_a: assert property (@(posedge CLK) disable iff (!RESET_N)
		!CE |=> memctl_q == $past(memctl_q) && FLASH_READS == $past(FLASH_READS))
		else $error("enable freeze");
	valid_a: assert property (@(posedge CLK) disable iff (!RESET_N)
		U_VALID |-> (region == ummd_pkg::RG_FLASH || region == ummd_pkg::RG_SFR
		|| region == ummd_pkg::RG_SRAM)) else $error("valid region");
	bit_wr_a: assert property (@(posedge CLK) disable iff (!RESET_N)
		(CE && D_WR && D_BIT && !d_is_sfr && D_BITOK)
		|=> idata_q[$past(dsel)][$past(D_BITSEL)] == $past(D_WDATA[0])) else $error("bit write");
	scramble_a: assert property (@(posedge CLK) disable iff (!RESET_N)
		(CE && VARIANT == ummd_pkg::UMMD_F32 && exit_s2_q && !U_WR
		&& (pm_sync2_q == ummd_pkg::PM_TWO || pm_sync2_q == ummd_pkg::PM_THREE)
		&& U_ADDR >= ummd_pkg::VOLATILE_LO && U_ADDR <= ummd_pkg::HOLE_HI)
		|=> sram_q[$past(U_ADDR[11:0])] == 8'hFF) else $error("volatile bytes");
	keep_sram_a: assert property (@(posedge CLK) disable iff (!RESET_N)
		(CE && !U_WR && U_ADDR >= ummd_pkg::SRAM_LO && U_ADDR < ummd_pkg::VOLATILE_LO)
		|=> sram_q[$past(U_ADDR[11:0])] == $past(sram_q[U_ADDR[11:0]])) else $error("sram lost");
	direct_low_a: assert property (@(posedge CLK) disable iff (!RESET_N)
		(D_ADDR < ummd_pkg::UPPER_HALF || D_INDIRECT) |-> !D_SFR_SEL) else $error("low data");
	memctl_rd_a: assert property (@(posedge CLK) disable iff (!RESET_N)
		(CE && D_SFR_SEL && D_ADDR == ummd_pkg::MEMCTL_ADDR)
		|=> D_RDATA == $past(memctl_q)) else $error("memctl read");
	sram_rd_a: assert property (@(posedge CLK) disable iff (!RESET_N)
		(CE && U_RD && !U_WR && region == ummd_pkg::RG_SRAM && U_ADDR < ummd_pkg::DATA_ALIAS_LO)
		|=> U_RDATA == $past(sram_q[U_ADDR[11:0]])) else $error("sram read");
	cov_alias_c: cover property (@(posedge CLK) U_RD && U_ADDR >= ummd_pkg::DATA_ALIAS_LO);
	cov_power_c: cover property (@(posedge CLK) exit_s2_q && pm_sync2_q == ummd_pkg::PM_THREE);
	cov_core_c: cover property (@(posedge CLK) U_DMA && sfr_core_mirror);
endmodule

// ===== rtl/ummd_pkg.sv
// What this block does
// - internal data bytes also appear at unified 0xFF00..0xFFFF
// - upper 128 data bytes only indirect; direct addresses there pick SFRs
// - lowest 48 data bytes form four register banks
// - data bytes 0x20..0x2F are bit addressable
// - internal data memory keeps its contents in all power modes
// - SFRs mirrored in unified space at 0xDF80..0xDFFF
// - core-internal SFRs only via SFR space, never mirror or DMA
// - 128 SFR addresses decoded and routed to their owner
// - SRAM of 1, 2 or 4 KB sits in 0xF000..0xFFFF
// - SRAM is not initialised at power-on
// - 0xF300..0xFEFF (8 KB) and 0xF700..0xFEFF (16 KB) unimplemented
// - 32 KB part: 0xFDA2..0xFEFF may be lost in power modes two and three
// - flash holds 8192, 16384 or 32768 bytes
// - flash is 1 KB main pages, up to 32, plus one information page
// - information page chosen only by debug configuration; write data port writes blocked while it is selected
// - instruction fetches from flash go through an instruction cache
// - cache disable bit makes every fetch go directly to flash
// - writable register bits keep their values through power modes two, three
// - code and external data spaces map identically
// - flash mapped from 0x0000 to 0x1FFF, 0x3FFF or 0x7FFF
// - SFRs at multiples of eight are bit addressable
package ummd_pkg;
	localparam logic [15:0] FLASH_BASE = 16'h0000;
	localparam logic [15:0] FLASH_END_8K = 16'h1FFF;
	localparam logic [15:0] FLASH_END_16K = 16'h3FFF;
	localparam logic [15:0] FLASH_END_32K = 16'h7FFF;
	localparam logic [15:0] SFR_MIRROR_LO = 16'hDF80;
	localparam logic [15:0] SFR_MIRROR_HI = 16'hDFFF;
	localparam logic [15:0] SRAM_LO = 16'hF000;
	localparam logic [15:0] SRAM_HI = 16'hFFFF;
	localparam logic [15:0] DATA_ALIAS_LO = 16'hFF00;
	localparam logic [15:0] HOLE_8K_LO = 16'hF300;
	localparam logic [15:0] HOLE_16K_LO = 16'hF700;
	localparam logic [15:0] HOLE_HI = 16'hFEFF;
	localparam logic [15:0] VOLATILE_LO = 16'hFDA2;
	localparam logic [7:0] UPPER_HALF = 8'h80;
	localparam logic [7:0] BANK_TOP = 8'h2F;
	localparam logic [7:0] BITBYTE_LO = 8'h20;
	localparam logic [7:0] BITBYTE_HI = 8'h2F;
	localparam logic [7:0] MEMCTL_ADDR = 8'hC7;
	localparam logic [7:0] FLASH_WRITE_DATA_PORT_PORT_ADDR = 8'hAF;
	localparam int MEMCTL_CACHE_BIT = 1;
	localparam logic [7:0] MEMCTL_RESET = 8'h00;
	localparam int SRAM_BYTES = 4096;
	localparam int FLASH_BYTES = 32768;
	localparam int PAGE_BYTES = 1024;
	localparam int LINE_WORDS = 4;
	typedef enum logic [1:0] {UMMD_F8, UMMD_F16, UMMD_F32} ummd_variant_t;
	typedef enum logic [2:0] {RG_NONE, RG_FLASH, RG_SFR, RG_SRAM, RG_HOLE} ummd_region_t;
	typedef enum logic [1:0] {PM_ACTIVE, PM_ONE, PM_TWO, PM_THREE} ummd_pmode_t;
endpackage

// ===== verification/ummd_core_model.sv
`timescale 1ns/1ps
module ummd_core_model (
	input wire logic clk,
	output logic [15:0] u_addr,
	output logic u_rd,
	output logic u_wr,
	output logic u_fetch,
	output logic u_dma,
	output logic [7:0] u_wdata,
	input wire logic [7:0] u_rdata,
	output logic [7:0] d_addr,
	output logic d_indirect,
	output logic d_rd,
	output logic d_wr,
	output logic [7:0] d_wdata,
	output logic d_bit,
	output logic [2:0] d_bitsel,
	input wire logic [7:0] d_rdata
);
	initial
	begin
		{u_addr, u_rd, u_wr, u_fetch, u_dma, u_wdata} = 29'h0;
		{d_addr, d_indirect, d_rd, d_wr, d_wdata, d_bit, d_bitsel} = 23'h0;
	end
	// unified access, kind 0 read, 1 write, 2 fetch, 3 dma read
	task automatic uni(input logic [1:0] kind, input logic [15:0] a, input logic [7:0] wd,
		output logic [7:0] rd);
		@(negedge clk);
		u_addr = a;
		u_wdata = wd;
		u_rd = kind[0] == kind[1];
		u_wr = kind == 2'h1;
		u_fetch = kind == 2'h2;
		u_dma = kind == 2'h3;
		@(posedge clk);
		@(negedge clk);
		rd = u_rdata;
		{u_rd, u_wr, u_fetch, u_dma} = 4'h0;
		u_wdata = ~wd;
	endtask
	// native data or sfr access
	task automatic dat(input logic wr, input logic ind, input logic [7:0] a,
		input logic [7:0] wd, output logic [7:0] rd);
		@(negedge clk);
		{d_bit, d_addr, d_indirect, d_wdata, d_wr, d_rd} = {1'b0, a, ind, wd, wr, !wr};
		@(posedge clk);
		@(negedge clk);
		rd = d_rdata;
		{d_wr, d_rd} = 2'h0;
		d_wdata = ~wd;
	endtask
	// address only, for the combinational decode outputs
	task automatic dset(input logic ind, input logic [7:0] a);
		@(negedge clk);
		{d_addr, d_indirect, d_bit, d_bitsel} = {a, ind, 1'b1, a[2:0]};
		#1;
	endtask
	task automatic uset(input logic [15:0] a);
		@(negedge clk);
		u_addr = a;
		#1;
	endtask
endmodule

// ===== verification/unified_memory_map_decoder_bench.sv
`timescale 1ns/1ps
module unified_memory_map_decoder_bench;
	localparam logic [127:0] CORE_MASK = 128'h1 << 8'h60;
	logic clk, reset_n, ce, pm_exit, dbg_info, u_rd, u_wr, u_fetch, u_dma, u_valid;
	logic d_indirect, d_rd, d_wr, d_bit, d_sfr_sel, d_sfr_core, d_in_bank, d_bitok;
	logic info_sel, cache_byp;
	logic [1:0] pmode;
	logic [2:0] u_region, d_bitsel;
	logic [5:0] flash_page;
	logic [6:0] d_sfr_idx;
	logic [7:0] u_wdata, u_rdata, d_addr, d_wdata, d_rdata, r;
	logic [15:0] u_addr;
	logic [31:0] flash_reads, n0;
	logic [7:0] probe [7] = '{8'h00, 8'h1F, 8'h20, 8'h2F, 8'h30, 8'h88, 8'h89};
	logic [15:0] ua [9] = '{16'h0000, 16'h7FFF, 16'h8000, 16'hDF7F, 16'hDF80, 16'hDFFF,
		16'hF000, 16'hFDA2, 16'hFFFF};
	logic [2:0] ureg [9] = '{3'h1, 3'h1, 3'h0, 3'h0, 3'h2, 3'h2, 3'h3, 3'h3, 3'h3};
	int miscompares = 0;
	int checks_done = 0;
	ummd_decoder #(.VARIANT(ummd_pkg::UMMD_F32), .CORE_SFR_MASK(CORE_MASK)) dut (.CLK(clk),
		.RESET_N(reset_n), .CE(ce), .U_ADDR(u_addr), .U_RD(u_rd), .U_WR(u_wr),
		.U_FETCH(u_fetch), .U_DMA(u_dma), .U_WDATA(u_wdata), .U_RDATA(u_rdata),
		.U_VALID(u_valid), .U_REGION(u_region), .D_ADDR(d_addr), .D_INDIRECT(d_indirect),
		.D_RD(d_rd), .D_WR(d_wr), .D_WDATA(d_wdata), .D_BIT(d_bit), .D_BITSEL(d_bitsel),
		.D_RDATA(d_rdata), .D_SFR_SEL(d_sfr_sel), .D_SFR_IDX(d_sfr_idx),
		.D_SFR_CORE(d_sfr_core), .D_IN_BANK(d_in_bank), .D_BITOK(d_bitok),
		.POWER_MODE(pmode), .PM_EXIT(pm_exit), .DBG_INFO_PAGE(dbg_info),
		.INFO_PAGE_SEL(info_sel), .FLASH_PAGE(flash_page), .CACHE_BYPASS(cache_byp),
		.FLASH_READS(flash_reads));
	ummd_core_model core (.clk(clk), .u_addr(u_addr), .u_rd(u_rd), .u_wr(u_wr),
		.u_fetch(u_fetch), .u_dma(u_dma), .u_wdata(u_wdata), .u_rdata(u_rdata),
		.d_addr(d_addr), .d_indirect(d_indirect), .d_rd(d_rd), .d_wr(d_wr),
		.d_wdata(d_wdata), .d_bit(d_bit), .d_bitsel(d_bitsel), .d_rdata(d_rdata));
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask
	task automatic print_verdict;
		$display("%0d checks, %0d mismatches", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// the tests need well under 300 cycles
	initial
	begin
		repeat (3000) @(posedge clk);
		miscompares++;
		print_verdict();
	end
	initial
	begin
		{reset_n, ce, pm_exit, dbg_info, pmode} = 6'h10;
		repeat (5) @(posedge clk);
		check(u_rdata, 8'h00);
		check(flash_reads, 32'h0);
		check(cache_byp, 1'b0);
		@(negedge clk);
		reset_n = 1'b1;
		$display("test reset done");
		core.dat(1'b1, 1'b0, 8'h10, 8'hA5, r);
		core.uni(2'h0, 16'hFF10, 8'h00, r);
		check(r, 8'hA5);
		core.uni(2'h1, 16'hFF90, 8'h3C, r);
		core.dat(1'b0, 1'b1, 8'h90, 8'h00, r);
		check(r, 8'h3C);
		core.dset(1'b0, 8'h90);
		check(d_sfr_sel, 1'b1);
		check(d_sfr_idx, 7'h10);
		core.dset(1'b1, 8'h90);
		check(d_sfr_sel, 1'b0);
		foreach (probe[i])
		begin
			core.dset(1'b0, probe[i]);
			check(d_in_bank, probe[i] <= 8'h2F);
			check(d_bitok, (probe[i] >= 8'h20 && probe[i] <= 8'h2F) || (probe[i][7] && probe[i][2:0] == 3'h0));
		end
		$display("test data space done");
		ce = 1'b0;
		core.uni(2'h1, 16'hDFC7, 8'h02, r);
		ce = 1'b1;
		check(cache_byp, 1'b0);
		core.uni(2'h1, 16'hDFC7, 8'h02, r);
		check(cache_byp, 1'b1);
		core.dat(1'b0, 1'b0, 8'hC7, 8'h00, r);
		check(r, 8'h02);
		core.dat(1'b1, 1'b0, 8'hE0, 8'h77, r);
		core.dat(1'b0, 1'b0, 8'hE0, 8'h00, r);
		check(r, 8'h77);
		core.uni(2'h0, 16'hDFE0, 8'h00, r);
		check(r, 8'h00);
		core.uni(2'h3, 16'hDFE0, 8'h00, r);
		check(r, 8'h00);
		core.dset(1'b0, 8'hE0);
		check(d_sfr_core, 1'b1);
		$display("test sfr done");
		foreach (ua[i])
		begin
			core.uset(ua[i]);
			check(u_region, ureg[i]);
			if (ureg[i] == 3'h1)
				check(flash_page, ua[i][15:10]);
		end
		$display("test map done");
		core.uni(2'h1, 16'hF000, 8'h96, r);
		core.uni(2'h1, 16'hFDA1, 8'h4B, r);
		core.uni(2'h2, 16'hF000, 8'h00, r);
		check(r, 8'h96);
		pmode = 2'h3;
		repeat (4) @(negedge clk);
		pm_exit = 1'b1;
		repeat (4) @(negedge clk);
		{pmode, pm_exit} = 3'h0;
		core.uni(2'h0, 16'hF000, 8'h00, r);
		check(r, 8'h96);
		core.uni(2'h0, 16'hFDA1, 8'h00, r);
		check(r, 8'h4B);
		core.uni(2'h0, 16'hFF10, 8'h00, r);
		check(r, 8'hA5);
		check(cache_byp, 1'b1);
		$display("test power done");
		n0 = flash_reads;
		repeat (2)
			core.uni(2'h2, 16'h0100, 8'h00, r);
		check(flash_reads - n0, 32'h2);
		core.dat(1'b1, 1'b0, 8'hC7, 8'h00, r);
		n0 = flash_reads;
		for (int i = 0; i < 8; i++)
			core.uni(2'h2, 16'h0200 + 16'(i % 4), 8'h00, r);
		check(flash_reads - n0, 32'h1);
		$display("test cache done");
		dbg_info = 1'b1;
		for (int i = 0; i < 8 && info_sel !== 1'b1; i++)
			@(negedge clk);
		check(info_sel, 1'b1);
		$display("test info page done");
		print_verdict();
	end
endmodule
